// >>> cmb_store.sv
/*
  CAN message buffer store: two-stage receive FIFO and three prioritised
  transmit buffers, reached by software over Avalon-MM with waitrequest.
  Assumes a protocol engine on the same clock that writes received bytes,
  reports frame ends and transmit events, and reads the selected buffer.
*/
`timescale 1ns/1ps
`default_nettype none

module cmb_store
  import cmb_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rstn,
  // Avalon-MM slave.
  input wire logic [8:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Receive side of the protocol engine.
  input wire cmb_rx_byte_t rx_byte,
  input wire cmb_rx_end_t rx_end,
  output logic bg_locked,
  output logic self_ack_en,
  // Transmit side of the protocol engine.
  input wire cmb_tx_evt_t tx_evt,
  input wire logic [3:0] tx_rd_idx,
  output logic tx_pending,
  output logic tx_active,
  output logic [1:0] tx_sel,
  output logic [7:0] tx_rd_data,
  // Interrupt request levels.
  output logic rx_irq,
  output logic tx_irq,
  output logic err_irq
);

  // Maps a byte address onto a register class, bank and byte index.
  function automatic cmb_dec_t decode(input logic [8:0] a);
    cmb_dec_t d;
    d.kind = REG_NONE;
    d.bank = a[7:6];
    d.idx = a[5:2];
    if (a[8] == OFS_TX_BASE[8]) begin
      if (a[7:6] != TX_BANK_NONE) begin
        if (a[5:2] < MSG_LEN) begin
          d.kind = REG_TX_BYTE;
        end else if (a[5:2] == LOCAL_PRIORITY_FIELD_IDX) begin
          d.kind = REG_TX_LOCAL_PRIORITY_FIELD;
        end
      end
    end else if (a[7:6] == OFS_FG_BASE[7:6] && a[5:2] < MSG_LEN) begin
      d.kind = REG_FG;
    end else begin
      unique case ({a[8:2], 2'h0})
        OFS_RX_FLAG: d.kind = REG_RX_FLAG;
        OFS_RX_CTRL: d.kind = REG_RX_CTRL;
        OFS_TX_FLAG: d.kind = REG_TX_FLAG;
        OFS_TX_CTRL: d.kind = REG_TX_CTRL;
        default: d.kind = REG_NONE;
      endcase
    end
    return d;
  endfunction : decode

  // Storage.
  logic [7:0] bg_ff [MSG_BYTES];
  logic [7:0] fg_ff [MSG_BYTES];
  logic [7:0] txb_ff [NUM_TX][MSG_BYTES];
  logic [7:0] local_priority_field_ff [NUM_TX];

  // Control and status.
  logic wait_ff;
  logic [31:0] rdata_ff;
  logic rxf_ff;
  logic bg_full_ff;
  logic ovr_ff;
  logic rxie_ff;
  logic ovrie_ff;
  logic loop_ff;
  logic [2:0] txe_ff;
  logic [2:0] abort_ack_ff;
  logic [2:0] abort_request_ff;
  logic [2:0] txie_ff;
  logic in_tx_ff;
  logic [1:0] active_ff;
  logic pend_ff;
  logic [7:0] txrd_ff;
  logic rx_irq_ff;
  logic tx_irq_ff;
  logic err_irq_ff;

  // Bus decode and write strobes. A request acts only in its answer cycle,
  // while waitrequest is low, so a held request writes exactly once.
  cmb_dec_t dec;
  logic acc;
  logic wr_en;
  logic [7:0] wd;
  assign dec = decode(avs_address);
  assign acc = (avs_read || avs_write) && !wait_ff;
  assign wr_en = acc && avs_write && avs_byteenable[0];
  assign wd = avs_writedata[7:0];

  // Host clears and schedules.
  logic clr_rxf;
  logic clr_ovr;
  logic [2:0] sched_wr;
  logic [2:0] abort_wr;
  assign clr_rxf = wr_en && dec.kind == REG_TX_FLAG ? 1'b0 :
                   wr_en && dec.kind == REG_RX_FLAG && wd[RXF_BIT];
  assign clr_ovr = wr_en && dec.kind == REG_RX_FLAG && wd[OVR_BIT];
  assign sched_wr = (wr_en && dec.kind == REG_TX_FLAG) ?
                    wd[TXE_LSB +: NUM_TX] & txe_ff : 3'h0;
  assign abort_wr = (wr_en && dec.kind == REG_TX_CTRL) ?
                    wd[ABORT_REQUEST_LSB +: NUM_TX] & ~txe_ff : 3'h0;

  // Receive frame end that counts as a normal incoming message.
  logic rx_take;
  assign rx_take = rx_end.done && rx_end.accepted &&
                   (!rx_end.own || loop_ff);

  // Transmit scheduling: lowest priority value among scheduled buffers.
  // Buffers waiting for an abort are left out of the choice.
  logic [2:0] sched;
  logic [2:0] abort_now;
  logic found;
  logic [1:0] pick;
  logic tx_ok;
  logic tx_end;
  always_comb begin
    found = 1'b0;
    pick = 2'h0;
    for (int b = 0; b < NUM_TX; b++) begin
      sched[b] = !txe_ff[b] && !abort_request_ff[b];
      abort_now[b] = abort_request_ff[b] && !txe_ff[b] &&
                     !(in_tx_ff && active_ff == 2'(b));
      if (sched[b] && (!found || local_priority_field_ff[b] < local_priority_field_ff[pick])) begin
        found = 1'b1;
        pick = 2'(b);
      end
    end
  end
  assign tx_ok = in_tx_ff && tx_evt.tx_ok;
  assign tx_end = in_tx_ff && (tx_evt.tx_ok || tx_evt.arb_lost || tx_evt.tx_err);

  // Read data selection.
  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (dec.kind)
      REG_FG: rd_word[7:0] = fg_ff[dec.idx];
      REG_RX_FLAG: begin
        rd_word[RXF_BIT] = rxf_ff;
        rd_word[OVR_BIT] = ovr_ff;
      end
      REG_RX_CTRL: begin
        rd_word[RXIE_BIT] = rxie_ff;
        rd_word[OVRIE_BIT] = ovrie_ff;
        rd_word[LOOP_BIT] = loop_ff;
      end
      REG_TX_FLAG: begin
        rd_word[TXE_LSB +: NUM_TX] = txe_ff;
        rd_word[ABORT_ACK_LSB +: NUM_TX] = abort_ack_ff;
      end
      REG_TX_CTRL: begin
        rd_word[ABORT_REQUEST_LSB +: NUM_TX] = abort_request_ff;
        rd_word[TXIE_LSB +: NUM_TX] = txie_ff;
      end
      REG_TX_BYTE: rd_word[7:0] = txb_ff[dec.bank][dec.idx];
      REG_TX_LOCAL_PRIORITY_FIELD: rd_word[7:0] = local_priority_field_ff[dec.bank];
      REG_NONE: rd_word = 32'h0000_0000;
    endcase
  end

  // Bus handshake: every request waits one cycle, then is answered.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wait_ff <= 1'b1;
      rdata_ff <= 32'h0000_0000;
    end else if ((avs_read || avs_write) && wait_ff) begin
      wait_ff <= 1'b0;
      rdata_ff <= avs_read ? rd_word : 32'h0000_0000;
    end else begin
      wait_ff <= 1'b1;
    end
  end

  // Receive control register and transmit interrupt enables.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rxie_ff <= 1'b0;
      ovrie_ff <= 1'b0;
      loop_ff <= 1'b0;
      txie_ff <= 3'h0;
    end else if (wr_en && dec.kind == REG_RX_CTRL) begin
      rxie_ff <= wd[RXIE_BIT];
      ovrie_ff <= wd[OVRIE_BIT];
      loop_ff <= wd[LOOP_BIT];
    end else if (wr_en && dec.kind == REG_TX_CTRL) begin
      txie_ff <= wd[TXIE_LSB +: NUM_TX];
    end
  end

  // Background slot: written byte by byte unless it holds a waiting message.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < MSG_BYTES; i++) begin
        bg_ff[i] <= BYTE_RST;
      end
    end else if (rx_byte.valid && !bg_full_ff && rx_byte.idx < MSG_LEN) begin
      bg_ff[rx_byte.idx] <= rx_byte.data;
    end
  end

  // Foreground slot and receive flags. A clear that meets a waiting background
  // message reloads the foreground at once, so the flag never drops between
  // two messages; a new message that meets a clear is copied, so set wins.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < MSG_BYTES; i++) begin
        fg_ff[i] <= BYTE_RST;
      end
      rxf_ff <= 1'b0;
      bg_full_ff <= 1'b0;
    end else if (bg_full_ff && clr_rxf) begin
      fg_ff <= bg_ff;
      rxf_ff <= 1'b1;
      bg_full_ff <= 1'b0;
    end else if (rx_take && !bg_full_ff && (!rxf_ff || clr_rxf)) begin
      fg_ff <= bg_ff;
      rxf_ff <= 1'b1;
    end else if (rx_take && !bg_full_ff) begin
      bg_full_ff <= 1'b1;
    end else if (clr_rxf) begin
      rxf_ff <= 1'b0;
    end
  end

  // Overrun flag: set wins over clear, clear ignored while both slots full.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ovr_ff <= 1'b0;
    end else if (rx_take && bg_full_ff) begin
      ovr_ff <= 1'b1;
    end else if (clr_ovr && !bg_full_ff) begin
      ovr_ff <= 1'b0;
    end
  end

  // Transmit buffer contents, writable while the buffer is not scheduled.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      for (int b = 0; b < NUM_TX; b++) begin
        local_priority_field_ff[b] <= LOCAL_PRIORITY_FIELD_RST;
        for (int i = 0; i < MSG_BYTES; i++) begin
          txb_ff[b][i] <= BYTE_RST;
        end
      end
    end else if (wr_en && dec.kind == REG_TX_BYTE && txe_ff[dec.bank]) begin
      txb_ff[dec.bank][dec.idx] <= wd;
    end else if (wr_en && dec.kind == REG_TX_LOCAL_PRIORITY_FIELD && txe_ff[dec.bank]) begin
      local_priority_field_ff[dec.bank] <= wd;
    end
  end

  // Per-buffer empty, abort request and abort acknowledge flags.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      txe_ff <= TXE_RST;
      abort_ack_ff <= 3'h0;
      abort_request_ff <= 3'h0;
    end else begin
      for (int b = 0; b < NUM_TX; b++) begin
        if (tx_ok && active_ff == 2'(b)) begin
          txe_ff[b] <= 1'b1;
          abort_ack_ff[b] <= 1'b0;
          abort_request_ff[b] <= 1'b0;
        end else if (abort_now[b]) begin
          txe_ff[b] <= 1'b1;
          abort_ack_ff[b] <= 1'b1;
          abort_request_ff[b] <= 1'b0;
        end else if (sched_wr[b]) begin
          txe_ff[b] <= 1'b0;
          abort_ack_ff[b] <= 1'b0;
        end else if (abort_wr[b]) begin
          abort_request_ff[b] <= 1'b1;
        end
      end
    end
  end

  // Arbitration: pick a buffer at an arbitration start while none is active, drop it at the end.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      in_tx_ff <= 1'b0;
      active_ff <= 2'h0;
    end else if (!in_tx_ff && tx_evt.arb_start && found) begin
      in_tx_ff <= 1'b1;
      active_ff <= pick;
    end else if (tx_end) begin
      in_tx_ff <= 1'b0;
    end
  end

  // Engine-facing outputs: scheduling request and buffer byte fetch.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pend_ff <= 1'b0;
      txrd_ff <= BYTE_RST;
    end else begin
      pend_ff <= |(sched & ~abort_now);
      txrd_ff <= tx_rd_idx < MSG_LEN ? txb_ff[active_ff][tx_rd_idx] : BYTE_RST;
    end
  end

  // Interrupt levels follow flags gated by their enables.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rx_irq_ff <= 1'b0;
      tx_irq_ff <= 1'b0;
      err_irq_ff <= 1'b0;
    end else begin
      rx_irq_ff <= rxf_ff && rxie_ff;
      tx_irq_ff <= |(txe_ff & txie_ff);
      err_irq_ff <= ovr_ff && ovrie_ff;
    end
  end

  // Output wiring from flip-flops.
  assign avs_waitrequest = wait_ff;
  assign avs_readdata = rdata_ff;
  assign bg_locked = bg_full_ff;
  assign self_ack_en = loop_ff;
  assign tx_pending = pend_ff;
  assign tx_active = in_tx_ff;
  assign tx_sel = active_ff;
  assign tx_rd_data = txrd_ff;
  assign rx_irq = rx_irq_ff;
  assign tx_irq = tx_irq_ff;
  assign err_irq = err_irq_ff;

endmodule : cmb_store
`default_nettype wire

// >>> cmb_pkg.sv
/*
  Package for the CAN message buffer store: register offsets, field
  positions, reset values and the packed carriers shared between the
  buffer store and the protocol engine that sits next to it.
  Assumes a 32-bit Avalon-MM slave port with byte addresses.
*/
package cmb_pkg;

  // Buffer geometry.
  localparam int NUM_TX = 3;
  localparam int MSG_BYTES = 13;
  localparam logic [3:0] MSG_LEN = 4'(MSG_BYTES);
  localparam logic [3:0] LOCAL_PRIORITY_FIELD_IDX = MSG_LEN;

  // Register byte offsets.
  localparam logic [8:0] OFS_FG_BASE = 9'h000;
  localparam logic [8:0] OFS_RX_FLAG = 9'h040;
  localparam logic [8:0] OFS_RX_CTRL = 9'h044;
  localparam logic [8:0] OFS_TX_FLAG = 9'h048;
  localparam logic [8:0] OFS_TX_CTRL = 9'h04c;
  localparam logic [8:0] OFS_TX_BASE = 9'h100;
  localparam logic [1:0] TX_BANK_NONE = 2'h3;

  // Field positions.
  localparam int RXF_BIT = 0;
  localparam int OVR_BIT = 1;
  localparam int RXIE_BIT = 0;
  localparam int OVRIE_BIT = 1;
  localparam int LOOP_BIT = 2;
  localparam int TXE_LSB = 0;
  localparam int ABORT_ACK_LSB = 4;
  localparam int ABORT_REQUEST_LSB = 0;
  localparam int TXIE_LSB = 4;

  // Reset values.
  localparam logic [2:0] TXE_RST = 3'h7;
  localparam logic [7:0] LOCAL_PRIORITY_FIELD_RST = 8'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;

  // One byte of an incoming frame written by the protocol engine.
  typedef struct packed {
    logic valid;
    logic [3:0] idx;
    logic [7:0] data;
  } cmb_rx_byte_t;

  // End of a correctly received frame.
  typedef struct packed {
    logic done;
    logic accepted;
    logic own;
  } cmb_rx_end_t;

  // Transmit events from the protocol engine.
  typedef struct packed {
    logic arb_start;
    logic tx_ok;
    logic arb_lost;
    logic tx_err;
  } cmb_tx_evt_t;

  // Register classes seen by the bus decoder.
  typedef enum logic [2:0] {
    REG_NONE, REG_FG, REG_RX_FLAG, REG_RX_CTRL, REG_TX_FLAG, REG_TX_CTRL,
    REG_TX_BYTE, REG_TX_LOCAL_PRIORITY_FIELD
  } cmb_reg_kind_t;

  typedef struct packed {
    cmb_reg_kind_t kind;
    logic [1:0] bank;
    logic [3:0] idx;
  } cmb_dec_t;

endpackage : cmb_pkg

// >>> cmb_store_chk.sv
/*
  Port checker for the CAN message buffer store.
  Assumes the bind below attaches it to every cmb_store instance.
*/
`timescale 1ns/1ps
`default_nettype none
module cmb_store_chk
  import cmb_pkg::*;
(
  // Clock, reset and bus handshake.
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // Protocol engine side.
  input wire cmb_rx_end_t rx_end,
  input wire logic bg_locked,
  input wire logic self_ack_en,
  input wire cmb_tx_evt_t tx_evt,
  input wire logic [3:0] tx_rd_idx,
  input wire logic tx_pending,
  input wire logic tx_active,
  input wire logic [1:0] tx_sel,
  input wire logic [7:0] tx_rd_data,
  // Interrupt levels.
  input wire logic rx_irq,
  input wire logic err_irq
);
  // All checks run on the module clock and rest during reset.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  a_bus_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest ##1 avs_waitrequest) else $error("bus answer is not one cycle");
  a_own_no_copy: assert property (rx_end.done && rx_end.own && !self_ack_en && !rx_irq
    && !avs_write && !$past(avs_write) |=> !rx_irq [*2]) else $error("own frame raised rx irq");
  a_rx_irq_sticky: assert property (rx_irq && !$past(avs_write) |=> rx_irq)
    else $error("rx irq fell without a clear");
  a_err_irq_sticky: assert property (err_irq && !$past(avs_write) |=> err_irq)
    else $error("overrun irq fell without a clear");
  a_bg_held: assert property (bg_locked && !avs_write && !$past(avs_write) |=> bg_locked)
    else $error("background slot released without host");
  a_active_held: assert property (tx_active && !(tx_evt.tx_ok || tx_evt.arb_lost
    || tx_evt.tx_err) |=> tx_active && $stable(tx_sel)) else $error("active buffer dropped");
  a_ok_release: assert property (tx_active && tx_evt.tx_ok |=> !tx_active)
    else $error("buffer still active after success");
  a_arb_grant: assert property (tx_evt.arb_start && !tx_active && tx_pending |=> tx_active)
    else $error("arbitration start not granted");
  a_rd_range: assert property (tx_rd_idx >= MSG_LEN |=> tx_rd_data == 8'h00)
    else $error("byte beyond buffer not zero");

  // Main scenarios reached.
  c_overrun: cover property (bg_locked && rx_end.done && rx_end.accepted);
  c_retry: cover property (tx_active && tx_evt.tx_err);
  c_loop: cover property (self_ack_en && rx_end.done && rx_end.own);
endmodule : cmb_store_chk

bind cmb_store cmb_store_chk chk_u (.ref_clk, .rstn, .avs_read, .avs_write, .avs_waitrequest,
  .rx_end, .bg_locked, .self_ack_en, .tx_evt, .tx_rd_idx, .tx_pending, .tx_active, .tx_sel,
  .tx_rd_data, .rx_irq, .err_irq);
`default_nettype wire

// >>> cmb_engine_model.sv
/*
  Behavioural protocol engine facing the buffer store: sends frames,
  arbitrates and reports transmit outcomes as the bench commands.
  Assumes the same clock as the store and one caller at a time.
*/
`timescale 1ns/1ps
`default_nettype none
module cmb_engine_model
  import cmb_pkg::*;
(
  // Clock.
  input wire logic ref_clk,
  // Events towards the store.
  output cmb_rx_byte_t rx_byte,
  output cmb_rx_end_t rx_end,
  output cmb_tx_evt_t tx_evt,
  output logic [3:0] tx_rd_idx,
  // Replies from the store.
  input wire logic [1:0] tx_sel,
  input wire logic [7:0] tx_rd_data
);
  // Idle values; the read index rests beyond the buffer.
  initial begin
    rx_byte = '0;
    rx_end = '0;
    tx_evt = '0;
    tx_rd_idx = 4'hf;
  end

  // Sends all thirteen bytes whatever the filter says, then the end mark.
  task automatic frame(input logic [7:0] base, input logic acc, input logic own);
    for (int i = 0; i < MSG_BYTES; i++) begin
      @(posedge ref_clk);
      rx_byte <= {1'b1, 4'(i), base + 8'(i)};
    end
    @(posedge ref_clk);
    rx_byte <= '0;
    @(posedge ref_clk);
    rx_end <= {1'b1, acc, own};
    @(posedge ref_clk);
    rx_end <= '0;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : frame

  // Starts arbitration and fetches byte 0 of the chosen buffer.
  task automatic arb(output logic [1:0] sel, output logic [7:0] b0);
    @(posedge ref_clk);
    tx_evt <= 4'b1000;
    tx_rd_idx <= 4'h0;
    @(posedge ref_clk);
    tx_evt <= '0;
    repeat (3) @(negedge ref_clk);
    sel = tx_sel;
    b0 = tx_rd_data;
    @(posedge ref_clk);
    tx_rd_idx <= 4'hf;
  endtask : arb

  // Reports the outcome of the frame on the bus.
  task automatic fin(input cmb_tx_evt_t e);
    @(posedge ref_clk);
    tx_evt <= e;
    @(posedge ref_clk);
    tx_evt <= '0;
    repeat (3) @(negedge ref_clk);
  endtask : fin
endmodule : cmb_engine_model
`default_nettype wire

// >>> test_cmb_store.sv
/*
  Self-checking bench for the CAN message buffer store.
  Assumes the engine model and the bound checker are compiled with it.
*/
`timescale 1ns/1ps
`default_nettype none
module test_cmb_store
  import cmb_pkg::*;
();
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [8:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata, q;
  logic avs_waitrequest, bg_locked, self_ack_en, tx_pending, tx_active, rx_irq, tx_irq, err_irq;
  cmb_rx_byte_t rx_byte;
  cmb_rx_end_t rx_end;
  cmb_tx_evt_t tx_evt;
  logic [3:0] tx_rd_idx;
  logic [1:0] tx_sel, sel;
  logic [7:0] tx_rd_data, b0;
  int num_errors = 0;
  int compares = 0;
  int cyc = 0;

  cmb_store dut_u (.ref_clk, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .rx_byte, .rx_end, .bg_locked,
    .self_ack_en, .tx_evt, .tx_rd_idx, .tx_pending, .tx_active, .tx_sel, .tx_rd_data,
    .rx_irq, .tx_irq, .err_irq);
  cmb_engine_model eng_u (.ref_clk, .rx_byte, .rx_end, .tx_evt, .tx_rd_idx, .tx_sel,
    .tx_rd_data);

  // Clock and hang guard.
  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      print_verdict();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One bus cycle held until waitrequest is sampled low at a rising edge.
  task automatic bus(input logic wr, input logic [8:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h000000, d};
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(negedge ref_clk);
  endtask : bus

  task automatic rc(input logic [8:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 8'h00);
    chk(nm, q, e);
  endtask : rc

  task automatic t_reset();
    rc(OFS_TX_FLAG, 32'h07, "tx flags");
    rc(OFS_RX_FLAG, 32'h00, "rx flags");
    rc(9'h1fc, 32'h00, "unmapped");
    $display("t_reset done");
  endtask : t_reset

  task automatic t_rx();
    bus(1'b1, OFS_RX_CTRL, 8'h03);
    eng_u.frame(8'h40, 1'b0, 1'b0);
    rc(OFS_RX_FLAG, 32'h00, "rejected");
    eng_u.frame(8'h50, 1'b1, 1'b0);
    rc(OFS_RX_FLAG, 32'h01, "rx full");
    rc(OFS_FG_BASE + 9'h030, 32'h5c, "last byte");
    chk("rx_irq", 32'(rx_irq), 32'h1);
    eng_u.frame(8'h60, 1'b1, 1'b0);
    chk("bg_locked", 32'(bg_locked), 32'h1);
    eng_u.frame(8'h70, 1'b1, 1'b0);
    rc(OFS_RX_FLAG, 32'h03, "overrun");
    chk("err_irq", 32'(err_irq), 32'h1);
    rc(OFS_FG_BASE, 32'h50, "fg kept");
    bus(1'b1, OFS_RX_FLAG, 8'h02);
    rc(OFS_RX_FLAG, 32'h03, "overrun held");
    bus(1'b1, OFS_RX_FLAG, 8'h01);
    rc(OFS_FG_BASE, 32'h60, "second msg");
    bus(1'b1, OFS_RX_FLAG, 8'h03);
    rc(OFS_RX_FLAG, 32'h00, "cleared");
    $display("t_rx done");
  endtask : t_rx

  task automatic t_own();
    eng_u.frame(8'h80, 1'b1, 1'b1);
    rc(OFS_RX_FLAG, 32'h00, "own frame");
    chk("self ack", 32'(self_ack_en), 32'h0);
    bus(1'b1, OFS_RX_CTRL, 8'h07);
    rc(OFS_RX_CTRL, 32'h07, "rx ctrl");
    chk("self ack", 32'(self_ack_en), 32'h1);
    eng_u.frame(8'h90, 1'b1, 1'b1);
    rc(OFS_FG_BASE, 32'h90, "looped msg");
    bus(1'b1, OFS_RX_FLAG, 8'h01);
    bus(1'b1, OFS_RX_CTRL, 8'h03);
    $display("t_own done");
  endtask : t_own

  task automatic t_tx();
    for (int b = 0; b < NUM_TX; b++) begin
      bus(1'b1, OFS_TX_BASE + 9'(b * 64) + 9'h034, 8'h30 - 8'(b * 16));
      bus(1'b1, OFS_TX_BASE + 9'(b * 64), 8'ha0 + 8'(b));
      rc(OFS_TX_BASE + 9'(b * 64) + 9'h034, 32'h30 - 32'(b * 16), "local_priority_field");
    end
    bus(1'b1, OFS_TX_CTRL, 8'h70);
    bus(1'b1, OFS_TX_FLAG, 8'h07);
    rc(OFS_TX_FLAG, 32'h00, "scheduled");
    chk("tx_irq", 32'(tx_irq), 32'h0);
    eng_u.arb(sel, b0);
    chk("first pick", 32'(sel), 32'h2);
    chk("tx byte", 32'(b0), 32'ha2);
    eng_u.fin(4'b0001);
    eng_u.arb(sel, b0);
    chk("retry pick", 32'(sel), 32'h2);
    eng_u.fin(4'b0100);
    rc(OFS_TX_FLAG, 32'h04, "sent");
    chk("tx_irq", 32'(tx_irq), 32'h1);
    chk("pending", 32'(tx_pending), 32'h1);
    eng_u.arb(sel, b0);
    chk("next pick", 32'(sel), 32'h1);
    eng_u.fin(4'b0010);
    eng_u.frame(8'hb0, 1'b1, 1'b0);
    rc(OFS_RX_FLAG, 32'h01, "lost then rx");
    bus(1'b1, OFS_TX_CTRL, 8'h71);
    rc(OFS_TX_FLAG, 32'h15, "aborted");
    eng_u.arb(sel, b0);
    chk("abort pick", 32'(sel), 32'h1);
    bus(1'b1, OFS_TX_CTRL, 8'h72);
    rc(OFS_TX_FLAG, 32'h15, "no abort on bus");
    rc(OFS_TX_CTRL, 32'h72, "abort pending");
    eng_u.fin(4'b0100);
    rc(OFS_TX_FLAG, 32'h17, "sent anyway");
    rc(OFS_TX_CTRL, 32'h70, "abort dropped");
    bus(1'b1, OFS_TX_FLAG, 8'h01);
    rc(OFS_TX_FLAG, 32'h06, "ack cleared");
    bus(1'b1, OFS_TX_BASE + 9'h034, 8'hff);
    rc(OFS_TX_BASE + 9'h034, 32'h30, "locked local_priority_field");
    $display("t_tx done");
  endtask : t_tx

  task automatic print_verdict();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict

  // Reset for 16 cycles, then the scenarios in turn.
  initial begin
    repeat (16) @(posedge ref_clk);
    rstn <= 1'b1;
    t_reset();
    t_rx();
    t_own();
    t_tx();
    print_verdict();
  end
endmodule : test_cmb_store
`default_nettype wire
